// [rtl/ebpwm_top.sv]
/*
  Enhanced bridge PWM block: three 8-bit period timers with prescalers,
  four PWM channels (two enhanced with four bridge outputs each, two standard),
  and an APB register slave.
  Assumes synchronous inputs on ref_clk and an outside pad ring that resolves
  pin level from pin_out and pin_oe.
*/
`timescale 1ns/100ps

module ebpwm_top
  import ebpwm_pkg::*;
(
  input  wire logic            ref_clk,  // System clock, 50 MHz.
  input  wire logic            reset,    // Synchronous reset, active high.
  input  wire logic            clk_en,   // Freezes all state while low.
  input  wire logic            sleep,    // Device sleep, stops counting.
  input  wire ebpwm_apb_req_t  apb_req,  // APB request from the master.
  output ebpwm_apb_rsp_t       apb_rsp,  // APB answer, registered.
  output logic [NPIN-1:0]      pin_out,  // Pin drive levels, registered.
  output logic [NPIN-1:0]      pin_oe    // Pin output enables, registered.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  ebpwm_state_t         st_r;
  ebpwm_state_t         st_nxt;
  logic [NTMR-1:0]      roll;      // Timer reaches period end this cycle.
  logic [NTMR-1:0][9:0] tbase;     // Ten-bit time base per timer.
  logic [NCH-1:0][1:0]  ch_tmr;    // Timer used by each channel.
  logic [NCH-1:0]       pwm_on;    // Channel is in a PWM channel mode.

  assign apb_rsp = st_r.rsp;
  assign pin_out = st_r.pin_out;
  assign pin_oe  = st_r.pin_oe;

  // Selects the prescaler limit for a timer control byte.
  function automatic logic [5:0] ps_limit(input logic [7:0] tc);
    logic [5:0] lim;
    lim = PS_LIM16;
    if (tc[1:0] == PS_DIV1)
    begin
      lim = PS_LIM1;
    end
    else if (tc[1:0] == PS_DIV4)
    begin
      lim = PS_LIM4;
    end
    return lim;
  endfunction : ps_limit

  // ---------------------------------------------------------------------------
  // Time base and channel routing signals
  // ---------------------------------------------------------------------------
  // Builds each time base and flags each period end; counts need the run bit.
  always_comb
  begin
    for (int t = 0; t < NTMR; t++)
    begin
      roll[t] = st_r.tcon[t][TCON_RUN] && (st_r.pre[t] == ps_limit(st_r.tcon[t]))
                && (st_r.tmr[t] == st_r.prm[t]);
      if (st_r.tcon[t][1:0] == PS_DIV1)
      begin
        tbase[t] = {st_r.tmr[t], st_r.pre[t][1:0]};
      end
      else if (st_r.tcon[t][1:0] == PS_DIV4)
      begin
        tbase[t] = {st_r.tmr[t], st_r.pre[t][3:2]};
      end
      else
      begin
        tbase[t] = {st_r.tmr[t], st_r.pre[t][5:4]};
      end
    end
    for (int c = 0; c < NCH; c++)
    begin
      ch_tmr[c] = (st_r.tsel[2*c +: 2] == 2'h3) ? 2'h0 : st_r.tsel[2*c +: 2];
      pwm_on[c] = (st_r.ctrl[c][3:2] == CM_PWM);
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Register access, timers, duty compare and pin mapping in one pass.
  always_comb
  begin
    logic [3:0]  lvl;
    logic [3:0]  used;
    logic        w;
    logic [1:0]  om;
    logic [31:0] rd;
    logic        hit;
    logic        wr;
    st_nxt = st_r;
    lvl    = 4'h0;
    used   = 4'h0;
    w      = 1'b0;
    om     = OM_SINGLE;
    rd     = 32'h0000_0000;
    hit    = 1'b0;
    wr     = apb_req.psel && apb_req.penable && apb_req.pwrite && st_r.rsp.pready;

    // Period counters advance only out of sleep, one count per 4*N clocks.
    for (int t = 0; t < NTMR; t++)
    begin
      if (!sleep && st_r.tcon[t][TCON_RUN])
      begin
        if (st_r.pre[t] == ps_limit(st_r.tcon[t]))
        begin
          st_nxt.pre[t] = 6'h00;
          st_nxt.tmr[t] = roll[t] ? 8'h00 : st_r.tmr[t] + 8'h01;
        end
        else
        begin
          st_nxt.pre[t] = st_r.pre[t] + 6'h01;
        end
      end
    end

    // Duty handling per channel.
    for (int c = 0; c < NCH; c++)
    begin
      if (!pwm_on[c])
      begin
        st_nxt.act[c]   = 1'b0;
        st_nxt.armed[c] = 1'b0;
      end
      else if (!sleep && roll[ch_tmr[c]])
      begin
        st_nxt.shadow[c] = {st_r.duty[c], st_r.ctrl[c][5:4]};
        st_nxt.act[c]    = ({st_r.duty[c], st_r.ctrl[c][5:4]} != 10'h000);
        st_nxt.armed[c]  = 1'b1;
      end
      else if (!sleep && (tbase[ch_tmr[c]] == st_r.shadow[c]))
      begin
        st_nxt.act[c] = 1'b0;
      end
    end

    // Enhanced channels map onto four bridge pins each.
    for (int c = 0; c < 2; c++)
    begin
      w  = st_r.act[c] && st_r.armed[c];
      om = st_r.ctrl[c][7:6];
      case (om)
        OM_HALF:
        begin
          lvl  = {2'b00, st_r.armed[c] && !st_r.act[c], w};
          used = 4'b0011;
        end
        OM_FWD:
        begin
          lvl  = {w, 1'b0, 1'b0, st_r.armed[c]};
          used = 4'b1111;
        end
        OM_REV:
        begin
          lvl  = {1'b0, st_r.armed[c], w, 1'b0};
          used = 4'b1111;
        end
        default:
        begin
          lvl  = {4{w}};
          used = st_r.steer[4*c +: 4];
        end
      endcase
      // Bit 1 inverts pins A and C, bit 0 inverts pins B and D.
      st_nxt.pin_out[4*c +: 4] = lvl ^ {st_r.ctrl[c][0], st_r.ctrl[c][1],
                                        st_r.ctrl[c][0], st_r.ctrl[c][1]};
      st_nxt.pin_oe[4*c +: 4]  = used & {4{pwm_on[c]}} & ~st_r.dir[4*c +: 4];
    end

    // Standard channels drive one pin each, active high.
    for (int c = 2; c < NCH; c++)
    begin
      st_nxt.pin_out[c+6] = st_r.act[c] && st_r.armed[c];
      st_nxt.pin_oe[c+6]  = pwm_on[c] && !st_r.dir[c+6];
    end

    // APB read decode, registered at the setup phase.
    for (int i = 0; i < NCH; i++)
    begin
      if (apb_req.paddr == OFF_CTRL + WORD_STEP * 12'(i))
      begin
        hit = 1'b1;
        rd  = {24'h000000, st_r.ctrl[i]};
      end
      if (apb_req.paddr == OFF_DUTY + WORD_STEP * 12'(i))
      begin
        hit = 1'b1;
        rd  = {24'h000000, st_r.duty[i]};
      end
      if (apb_req.paddr == OFF_SHADOW + WORD_STEP * 12'(i))
      begin
        hit = 1'b1;
        rd  = {24'h000000, st_r.shadow[i][9:2]};
      end
    end
    for (int t = 0; t < NTMR; t++)
    begin
      if (apb_req.paddr == OFF_PRM + WORD_STEP * 12'(t))
      begin
        hit = 1'b1;
        rd  = {24'h000000, st_r.prm[t]};
      end
      if (apb_req.paddr == OFF_TCON + WORD_STEP * 12'(t))
      begin
        hit = 1'b1;
        rd  = {25'h0, st_r.tcon[t][6:0]};
      end
      if (apb_req.paddr == OFF_TMR + WORD_STEP * 12'(t))
      begin
        hit = 1'b1;
        rd  = {24'h000000, st_r.tmr[t]};
      end
    end
    if (apb_req.paddr == OFF_TSEL)
    begin
      hit = 1'b1;
      rd  = {24'h000000, st_r.tsel};
    end
    if (apb_req.paddr == OFF_DIR)
    begin
      hit = 1'b1;
      rd  = {22'h0, st_r.dir};
    end
    if (apb_req.paddr == OFF_STEER)
    begin
      hit = 1'b1;
      rd  = {24'h000000, st_r.steer};
    end

    // Ready rises one cycle after setup and stays for exactly one cycle.
    st_nxt.rsp.pready = apb_req.psel && !apb_req.penable;
    if (apb_req.psel && !apb_req.penable)
    begin
      st_nxt.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd;
      st_nxt.rsp.pslverr = !hit;
    end

    // APB write, taken on the access edge only.
    if (wr)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (apb_req.paddr == OFF_CTRL + WORD_STEP * 12'(i))
        begin
          st_nxt.ctrl[i] = (i < 2) ? apb_req.pwdata[7:0]
                                   : {2'b00, apb_req.pwdata[5:0]};
        end
        if (apb_req.paddr == OFF_DUTY + WORD_STEP * 12'(i))
        begin
          st_nxt.duty[i] = apb_req.pwdata[7:0];
        end
      end
      for (int t = 0; t < NTMR; t++)
      begin
        if (apb_req.paddr == OFF_PRM + WORD_STEP * 12'(t))
        begin
          st_nxt.prm[t] = apb_req.pwdata[7:0];
        end
        if (apb_req.paddr == OFF_TCON + WORD_STEP * 12'(t))
        begin
          st_nxt.tcon[t] = {1'b0, apb_req.pwdata[6:0]};
        end
        if (apb_req.paddr == OFF_TMR + WORD_STEP * 12'(t))
        begin
          st_nxt.tmr[t] = apb_req.pwdata[7:0];
        end
      end
      if (apb_req.paddr == OFF_TSEL)
      begin
        st_nxt.tsel = apb_req.pwdata[7:0];
      end
      if (apb_req.paddr == OFF_DIR)
      begin
        st_nxt.dir = apb_req.pwdata[NPIN-1:0];
      end
      if (apb_req.paddr == OFF_STEER)
      begin
        st_nxt.steer = apb_req.pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register stage
  // ---------------------------------------------------------------------------
  // Reset restores every register and turns all pins into inputs.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_r         <= '0;
      st_r.prm     <= {NTMR{RST_PRM}};
      st_r.tsel    <= RST_BYTE;
      st_r.dir     <= RST_DIR;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_sleep_tmr_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && sleep) |=> $stable(st_r.tmr) && $stable(st_r.act))
    else $error("Counter or output moved during sleep.");

  chk_input_pins_off: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && (&st_r.dir)) |=> (st_r.pin_oe == '0))
    else $error("A pin is enabled while all pins are inputs.");

  chk_oe_needs_dir: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en |=> ((st_r.pin_oe & $past(st_r.dir)) == '0))
    else $error("A pin was enabled with its direction bit set.");

  chk_zero_ctrl_release: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && st_r.ctrl[0] == 8'h00) |=> (st_r.pin_oe[3:0] == 4'h0))
    else $error("Cleared control still drives a bridge pin.");

  chk_std_mode_bits: assert property (@(posedge ref_clk) disable iff (reset)
    (st_r.ctrl[2][7:6] == 2'b00) && (st_r.ctrl[3][7:6] == 2'b00))
    else $error("Standard channel output mode bits are not zero.");

  chk_half_unused: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && st_r.ctrl[0][7:6] == OM_HALF) |=> (st_r.pin_oe[3:2] == 2'b00))
    else $error("Half bridge drives pin C or D.");

  chk_shadow_latch: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && !sleep && pwm_on[0] && roll[ch_tmr[0]])
      |=> (st_r.shadow[0] == {$past(st_r.duty[0]), $past(st_r.ctrl[0][5:4])}) && st_r.armed[0])
    else $error("Duty not latched at period end.");

  chk_first_period: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && !st_r.armed[0] && !roll[ch_tmr[0]]) |=> !st_r.armed[0])
    else $error("Channel armed before a period start.");

  chk_clear_on_match: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && !sleep && pwm_on[0] && !roll[ch_tmr[0]]
      && tbase[ch_tmr[0]] == st_r.shadow[0]) |=> !st_r.act[0])
    else $error("Output not cleared at duty match.");

  chk_half_complement: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && st_r.ctrl[0][7:6] == OM_HALF && st_r.ctrl[0][1:0] == 2'b00 && st_r.armed[0])
      |=> (st_r.pin_out[1] != st_r.pin_out[0]))
    else $error("Half bridge pin B is not the complement of pin A.");

  chk_enable_freeze: assert property (@(posedge ref_clk) disable iff (reset)
    !clk_en |=> $stable(st_r))
    else $error("State moved while the clock enable was low.");

endmodule : ebpwm_top

// [rtl/ebpwm_pkg.sv]
/*
  Constants, register map and carrier types for the enhanced bridge PWM block.
  Assumes a 32-bit APB master and one 50 MHz system clock.
*/
package ebpwm_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL   = 12'h000;  // Channel control, four words.
  localparam logic [11:0] OFF_TSEL   = 12'h010;  // Timebase selection.
  localparam logic [11:0] OFF_DUTY   = 12'h014;  // Duty buffer bytes, four words.
  localparam logic [11:0] OFF_PRM    = 12'h024;  // Period match values, three words.
  localparam logic [11:0] OFF_TCON   = 12'h030;  // Timer controls, three words.
  localparam logic [11:0] OFF_TMR    = 12'h03c;  // Period counters, three words.
  localparam logic [11:0] OFF_DIR    = 12'h048;  // Pin direction bits.
  localparam logic [11:0] OFF_STEER  = 12'h04c;  // Steering enables.
  localparam logic [11:0] OFF_SHADOW = 12'h050;  // Duty shadow bytes, read only.
  localparam logic [11:0] WORD_STEP  = 12'h004;

  // ---------------------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------------------
  localparam int          CTL_OM_LSB = 6;        // Output mode field, bits 7:6.
  localparam int          CTL_DL_LSB = 4;        // Duty low bits, bits 5:4.
  localparam int          CTL_CM_LSB = 0;        // Channel mode field, bits 3:0.
  localparam logic [1:0]  CM_PWM     = 2'h3;     // Upper channel mode bits for PWM.
  localparam logic [1:0]  OM_SINGLE  = 2'h0;
  localparam logic [1:0]  OM_FWD     = 2'h1;
  localparam logic [1:0]  OM_HALF    = 2'h2;
  localparam logic [1:0]  OM_REV     = 2'h3;
  localparam int          TCON_RUN   = 2;        // Timer run bit.
  localparam logic [1:0]  PS_DIV1    = 2'h0;
  localparam logic [1:0]  PS_DIV4    = 2'h1;
  localparam logic [5:0]  PS_LIM1    = 6'h03;    // Four clocks per count at 1:1.
  localparam logic [5:0]  PS_LIM4    = 6'h0f;    // Sixteen clocks per count at 1:4.
  localparam logic [5:0]  PS_LIM16   = 6'h3f;    // Sixty-four clocks per count at 1:16.
  localparam int          NCH        = 4;
  localparam int          NTMR       = 3;
  localparam int          NPIN       = 10;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_PRM    = 8'hff;
  localparam logic [9:0]  RST_DIR    = 10'h3ff;  // Every pin an input.

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } ebpwm_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ebpwm_apb_rsp_t;

  typedef struct packed {
    logic [NCH-1:0][7:0]  ctrl;
    logic [7:0]           tsel;
    logic [NCH-1:0][7:0]  duty;
    logic [NTMR-1:0][7:0] prm;
    logic [NTMR-1:0][7:0] tcon;
    logic [NTMR-1:0][7:0] tmr;
    logic [NTMR-1:0][5:0] pre;
    logic [NCH-1:0][9:0]  shadow;
    logic [NCH-1:0]       act;
    logic [NCH-1:0]       armed;
    logic [NPIN-1:0]      dir;
    logic [7:0]           steer;
    logic [NPIN-1:0]      pin_out;
    logic [NPIN-1:0]      pin_oe;
    ebpwm_apb_rsp_t       rsp;
  } ebpwm_state_t;

endpackage : ebpwm_pkg

// [verification/ebpwm_load_model.sv]
/*
  Far-side load model: gate drivers with pull-downs on every bridge pin.
  Assumes pin_out and pin_oe come straight from the PWM block.
*/
`timescale 1ns/100ps

module ebpwm_load_model
  import ebpwm_pkg::*;
(
  input  wire logic [NPIN-1:0] pin_out,  // Levels from the block.
  input  wire logic [NPIN-1:0] pin_oe,   // Drive enables from the block.
  output logic      [NPIN-1:0] pin_lvl   // Resolved pad level.
);
  // ---------------------------------------------------------------------------
  // Pad resolution
  // ---------------------------------------------------------------------------
  // A released pin is pulled low, so a missing enable never passes for drive.
  always_comb pin_lvl = pin_out & pin_oe;
endmodule : ebpwm_load_model

// [verification/enhanced_bridge_pwm_output_tb_top.sv]
/*
  Self-checking bench for the enhanced bridge PWM block.
  Assumes the package constants and the load model on the pins.
*/
`timescale 1ns/100ps

module enhanced_bridge_pwm_output_tb_top
  import ebpwm_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Signals and reference model state
  // ---------------------------------------------------------------------------
  logic            ref_clk, reset, clk_en, sleep;
  ebpwm_apb_req_t  req;
  ebpwm_apb_rsp_t  rsp;
  logic [NPIN-1:0] pin_out, pin_oe, pin_lvl;
  logic [31:0]     rdat, r, q;
  logic            err;
  int              failures, samples_checked, hi, per, p, d, pres, k;
  int              kt[5][4] = '{'{2,3,4,4}, '{1,0,0,2}, '{0,2,1,0}, '{4,2,4,2}, '{0,1,1,3}};
  logic [1:0]      oml[5] = '{OM_HALF, OM_FWD, OM_REV, OM_SINGLE, OM_FWD};

  ebpwm_top u_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .sleep(sleep),
                   .apb_req(req), .apb_rsp(rsp), .pin_out(pin_out), .pin_oe(pin_oe));
  ebpwm_load_model u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));

  // Free-running system clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // A wait that ran out of time counts as a mismatch.
  task automatic tmo;
    failures++;
    $display("[ERR] wait expected done seen timeout");
    end_of_test();
  endtask : tmo

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    req <= '{a, 1'b1, 1'b0, w, wd};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      if (rsp.pready === 1'b1)
        break;
    end
    if (n >= 20)
      tmo();
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // Waits, bounded, until a pad shows the given level.
  task automatic wt(input int b, input logic v);
    int n;
    for (n = 0; n < 5000 && pin_lvl[b] !== v; n++)
      @(posedge ref_clk);
    if (n >= 5000)
      tmo();
  endtask : wt

  // Measures high time and period of one pad in clocks.
  task automatic meas(input int b, input bit first);
    if (!first)
      wt(b, 1'b0);
    wt(b, 1'b1);
    hi = 0;
    for (per = 1; per < 5000; per++)
    begin
      @(posedge ref_clk);
      if (pin_lvl[b] !== 1'b1 && hi == 0)
        hi = per;
      else if (pin_lvl[b] === 1'b1 && hi != 0)
        break;
    end
    if (per >= 5000)
      tmo();
  endtask : meas

  // Programs timer A and channel one from the model values p and d.
  task automatic pwm_on(input logic [1:0] om, input logic [3:0] cm, input logic [1:0] ps);
    apb(1'b1, OFF_PRM, 32'(p));
    apb(1'b1, OFF_TCON, {29'h0, 1'b1, ps});
    apb(1'b1, OFF_DUTY, 32'(d >> 2));
    apb(1'b1, OFF_TMR, 32'h0);
    apb(1'b1, OFF_CTRL, {24'h0, om, 2'(d), cm});
  endtask : pwm_on

  // Main sequence.
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    sleep = 1'b0;
    req = '0;
    failures = 0;
    samples_checked = 0;
    r = $urandom(20251);
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    chk("pin_oe", 32'(pin_oe), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, OFF_CTRL + 12'(4 * i), 32'h0);
      chk("ctrl", rdat, 32'h0);
    end
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, OFF_PRM + 12'(4 * i), 32'h0);
      chk("prm", rdat, 32'hff);
    end
    apb(1'b0, OFF_DIR, 32'h0);
    chk("dir", rdat, 32'h3ff);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    r = $urandom;
    apb(1'b1, OFF_CTRL + 12'h008, r);
    apb(1'b0, OFF_CTRL + 12'h008, 32'h0);
    chk("ctrl3", rdat, {26'h0, r[5:0]});
    apb(1'b1, OFF_CTRL, r);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl1", rdat, {24'h0, r[7:0]});
    apb(1'b1, OFF_CTRL, 32'h0);
    $display("register test done");
    // Every output mode, both polarities and all three prescalers.
    apb(1'b1, OFF_DIR, 32'h3f0);
    apb(1'b1, OFF_STEER, 32'h0a);
    for (int m = 0; m < 5; m++)
    begin
      p = 3 + $urandom % 13;
      d = 1 + $urandom % (4 * p + 2);
      pres = (m % 3 == 0) ? 1 : (m % 3 == 1) ? 4 : 16;
      pwm_on(oml[m], (m == 4) ? 4'hf : 4'hc, 2'(m % 3));
      repeat (8 * (p + 1) * pres + 8) @(posedge ref_clk);
      for (int b = 0; b < 4; b++)
      begin
        k = kt[m][b];
        if (k == 2 || k == 3)
        begin
          meas(b, 1'b0);
          chk("period", per, 4 * (p + 1) * pres);
          // The clear lands one clock after the match, so the high phase gains a clock.
          chk("high", hi, (k == 2) ? d * pres + 1 : (4 * (p + 1) - d) * pres - 1);
        end
        else
        begin
          chk("pin_oe", 32'(pin_oe[b]), 32'(k != 4));
          if (k < 2)
            chk("level", 32'(pin_out[b]), 32'(k));
        end
      end
      $display("mode test %0d done", m);
    end
    // Zero control releases pins; re-enable starts with a whole pulse.
    apb(1'b1, OFF_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("pin_oe", 32'(pin_oe[3:0]), 32'h0);
    p = 63;
    d = 200;
    pwm_on(OM_HALF, 4'hc, 2'h0);
    meas(0, 1'b1);
    chk("first", hi, d + 1);
    $display("enable test done");
    // Sleep freezes counter and pins, then counting resumes.
    sleep <= 1'b1;
    repeat (3) @(posedge ref_clk);
    q = 32'(pin_lvl);
    apb(1'b0, OFF_TMR, 32'h0);
    r = rdat;
    repeat (40) @(posedge ref_clk);
    apb(1'b0, OFF_TMR, 32'h0);
    chk("tmr", rdat, r);
    chk("pins", 32'(pin_lvl), q);
    sleep <= 1'b0;
    meas(0, 1'b0);
    chk("high", hi, d + 1);
    // Clock enable low freezes the running waveform on its pads for over a period.
    clk_en <= 1'b0;
    @(posedge ref_clk);
    q = 32'(pin_lvl);
    k = 0;
    repeat (300)
    begin
      @(posedge ref_clk);
      if (32'(pin_lvl) !== q)
        k++;
    end
    clk_en <= 1'b1;
    chk("frozen", 32'(k), 32'h0);
    $display("sleep test done");
    // A set direction bit keeps the waveform off its pin.
    apb(1'b1, OFF_DIR, 32'h3f1);
    repeat (3) @(posedge ref_clk);
    chk("pin_oe", 32'(pin_oe[3:0]), 32'h2);
    // Reset in mid-run restores registers and inputs.
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk("pin_oe", 32'(pin_oe), 32'h0);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl1", rdat, 32'h0);
    apb(1'b0, OFF_DIR, 32'h0);
    chk("dir", rdat, 32'h3ff);
    $display("reset test done");
    end_of_test();
  end
endmodule : enhanced_bridge_pwm_output_tb_top
